// *** hdl/mfil_pkg.sv ***
// package: constants and carrier types of the motor feedback input logic
package mfil_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_KHZ        = 20000;             // core clock rate, 20 MHz
  localparam int UPDATE_US      = 250;               // output rate update interval
  localparam int UPDATE_CYC     = UPDATE_US * CLK_KHZ / 1000;  // cycles per interval
  localparam int OUT_MAX_KHZ    = 2500;              // max regenerated signal rate
  // four edges per line, least gap rounds up to whole cycles
  localparam int STEP_GAP       = (CLK_KHZ + 4 * OUT_MAX_KHZ - 1) / (4 * OUT_MAX_KHZ);

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;       // control bits
  localparam logic [7:0] OFS_HALL_OFS = 8'h04;       // hall phase offset, degrees
  localparam logic [7:0] OFS_OUT_DIV  = 8'h08;       // regenerated output divisor
  localparam logic [7:0] OFS_POS      = 8'h0C;       // position count, read only
  localparam logic [7:0] OFS_IDX_POS  = 8'h10;       // position at last index
  localparam logic [7:0] OFS_STATE    = 8'h14;       // live state, read only
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;       // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;       // event enables

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [4:0] CTRL_RST     = 5'h03;       // halls and thermostat in use
  localparam logic [8:0] HALL_OFS_RST = 9'h000;      // no hall offset
  localparam logic [7:0] OUT_DIV_RST  = 8'h01;       // divide by one
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;        // all events masked
  localparam int EV_ILLEGAL = 0;                     // illegal quadrature change
  localparam int EV_INDEX   = 1;                     // index edge seen
  localparam int EV_HEAT    = 2;                     // motor overheat
  localparam int EV_HALL    = 3;                     // invalid hall code
  localparam int N_IN       = 9;                     // filtered input count

  // output regeneration modes
  typedef enum logic [1:0] {MFIL_BUFFERED, MFIL_INTERP, MFIL_DIVIDED, MFIL_RSVD} mfil_mode_t;

  // software control bits
  typedef struct packed {
    mfil_mode_t out_mode;                            // regenerated output mode
    logic       sincos;                              // sine/cosine phasing convention
    logic       thermo_en;                           // thermostat monitored
    logic       hall_en;                             // hall sensors in use
  } mfil_ctrl_t;

  // filtered pin levels
  typedef struct packed {
    logic       lim_neg;                             // negative limit open
    logic       lim_pos;                             // positive limit open
    logic       thermo;                              // thermostat open
    logic [2:0] hall;                                // hall 3..1
    logic       idx;                                 // index
    logic       b;                                   // channel b
    logic       a;                                   // channel a
  } mfil_pins_t;

endpackage : mfil_pkg

// *** hdl/mfil_top.sv ***
// module: motor encoder, hall, thermostat and limit front end with apb registers
// Operation
// R1: filter encoder channels and index before use
// R2: detect illegal quadrature state changes
// R3: count all edges, four per line
// R4: encoder keeps channel phase error bounded
// R5: halls set initial commutation angle when enabled
// R6: software can ignore hall inputs
// R7: software hall to back emf offset
// R8: open thermostat raises overheat fault
// R9: software can ignore thermostat input
// R10: open limit blocks that direction only
// R11: limit enable comes from motor configuration
// R12: positive direction increments position count
// R13: sine/cosine uses different phasing convention
// R14: regenerated outputs stay within 2.5 MHz; only divided mode paces them, other modes pass filtered inputs through
// R15: output rate updated every 250 us
// R16: divided mode reduces lines by divisor
// R17: loops use full count regardless divisor
// R18: illegal change holds count, sets sticky flag
// R19: limits act only when configured enabled
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module mfil_top #(
  parameter int UPDATE_CYCLES = mfil_pkg::UPDATE_CYC  // update interval, cycles
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        motor_channel_a,
  input  wire logic        motor_channel_b,
  input  wire logic        motor_index,
  input  wire logic        hall_sensor_1,
  input  wire logic        hall_sensor_2,
  input  wire logic        hall_sensor_3,
  input  wire logic        thermostat_in,
  input  wire logic        limit_pos_in,
  input  wire logic        limit_neg_in,
  input  wire logic        motor_limits_en,
  output logic             enc_out_a,
  output logic             enc_out_b,
  output logic [8:0]       comm_angle,
  output logic             comm_angle_valid,
  output logic             overheat_fault,
  output logic             fwd_inhibit,
  output logic             rev_inhibit,
  output logic             irq
);

  // ****************************************
  // input filters
  // ****************************************
  logic [mfil_pkg::N_IN-1:0] raw;                    // pins as a vector
  logic [mfil_pkg::N_IN-1:0] s0_q, s1_q, filt_q;     // sample chain and filtered level
  logic [mfil_pkg::N_IN-1:0] filt_d;                 // next filtered level
  mfil_pkg::mfil_pins_t      pin;                    // filtered levels by name
  assign raw = {limit_neg_in, limit_pos_in, thermostat_in, hall_sensor_3, hall_sensor_2,
                hall_sensor_1, motor_index, motor_channel_b, motor_channel_a};
  assign pin = mfil_pkg::mfil_pins_t'(filt_q);

  // a level is accepted once two samples agree; a one-cycle glitch never passes
  genvar gi;
  generate
    for (gi = 0; gi < mfil_pkg::N_IN; gi++) begin : g_filt
      always_comb begin
        filt_d[gi] = (s0_q[gi] == s1_q[gi]) ? s1_q[gi] : filt_q[gi];  // [R1]
      end
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          s0_q[gi]   <= 1'b0;
          s1_q[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s0_q[gi]   <= raw[gi];
          s1_q[gi]   <= s0_q[gi];
          filt_q[gi] <= filt_d[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // register file state
  // ****************************************
  mfil_pkg::mfil_ctrl_t ctrl_q, ctrl_d;              // control bits
  logic [8:0]  hall_ofs_q, hall_ofs_d;               // hall offset, degrees
  logic [7:0]  div_q, div_d;                         // output divisor
  logic [3:0]  stat_q, stat_d;                       // sticky events
  logic [3:0]  mask_q, mask_d;                       // event enables
  logic [31:0] prdata_d;                             // read mux
  logic        pready_d, pslverr_d, irq_d;
  logic [3:0]  ev;                                   // event pulses this cycle
  logic        wr_en;                                // write taken this edge

  // offset decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= mfil_pkg::OFS_IRQ_MASK);
  endfunction : mapped

  // ****************************************
  // decoder state
  // ****************************************
  logic        pa_q, pb_q, pi_q;                     // last decoded levels
  logic [31:0] pos_q, pos_d;                         // full x4 count
  logic [31:0] idx_pos_q, idx_pos_d;                 // count at index edge
  logic        mv_a, mv_b, mv_one, mv_both, mv_up;   // move classification
  assign mv_a    = pin.a != pa_q;
  assign mv_b    = pin.b != pb_q;
  assign mv_one  = mv_a ^ mv_b;
  assign mv_both = mv_a & mv_b;                      // [R2]
  // a leads b is positive for square wave, b leads a for sine/cosine
  assign mv_up   = (pin.a ^ pb_q) ^ ctrl_q.sincos;   // [R12] [R13]

  // count every edge of both channels; illegal moves leave count alone
  always_comb begin
    pos_d     = pos_q;
    idx_pos_d = idx_pos_q;
    if (mv_one) begin
      pos_d = mv_up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;  // [R3] [R17] [R18]
    end
    if (pin.idx && !pi_q) begin
      idx_pos_d = pos_q;                             // index rising edge
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pa_q      <= 1'b0;
      pb_q      <= 1'b0;
      pi_q      <= 1'b0;
      pos_q     <= 32'h0000_0000;
      idx_pos_q <= 32'h0000_0000;
    end else begin
      pa_q      <= pin.a;
      pb_q      <= pin.b;
      pi_q      <= pin.idx;
      pos_q     <= pos_d;
      idx_pos_q <= idx_pos_d;
    end
  end

  // ****************************************
  // halls, thermostat, limits
  // ****************************************
  logic [2:0] sector;                                // hall sector, 7 when invalid
  logic [9:0] ang_sum;                               // sector angle plus offset
  logic [8:0] ang_d;
  logic       ang_ok_d, heat_d, fwd_d, rev_d;
  logic [8:0] ang_q;
  logic       ang_ok_q, heat_q, fwd_q, rev_q;

  // hall code to sector for the positive sequence
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'b001:  hall_sector = 3'd0;
      3'b011:  hall_sector = 3'd1;
      3'b010:  hall_sector = 3'd2;
      3'b110:  hall_sector = 3'd3;
      3'b100:  hall_sector = 3'd4;
      3'b101:  hall_sector = 3'd5;
      default: hall_sector = 3'd7;                   // 000 and 111 never legal
    endcase
  endfunction : hall_sector

  always_comb begin
    sector   = hall_sector(pin.hall);
    ang_sum  = 10'(sector) * 10'd60 + 10'(hall_ofs_q);  // [R7]
    // offset may be written up to 511, so wrap up to twice
    if (ang_sum >= 10'd720) begin
      ang_sum = ang_sum - 10'd720;
    end else if (ang_sum >= 10'd360) begin
      ang_sum = ang_sum - 10'd360;
    end
    ang_d    = ang_sum[8:0];
    ang_ok_d = ctrl_q.hall_en && (sector != 3'd7);   // [R5] [R6]
    heat_d   = ctrl_q.thermo_en && pin.thermo;       // [R8] [R9]
    fwd_d    = motor_limits_en && pin.lim_pos;       // [R10] [R11] [R19]
    rev_d    = motor_limits_en && pin.lim_neg;       // [R10] [R11] [R19]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ang_q    <= 9'h000;
      ang_ok_q <= 1'b0;
      heat_q   <= 1'b0;
      fwd_q    <= 1'b0;
      rev_q    <= 1'b0;
    end else begin
      ang_q    <= ang_ok_d ? ang_d : ang_q;          // hold last good angle
      ang_ok_q <= ang_ok_d;
      heat_q   <= heat_d;
      fwd_q    <= fwd_d;
      rev_q    <= rev_d;
    end
  end

  // ****************************************
  // encoder output regeneration
  // ****************************************
  logic [12:0] tick_cnt_q, tick_cnt_d;               // update interval counter
  logic        tick_q, tick_d;                       // interval boundary pulse
  logic signed [8:0]  pre_q, pre_d;                  // divider prescaler
  logic signed [15:0] pend_q, pend_d;                // steps gathered this interval
  logic signed [15:0] burst_q, burst_d;              // steps owed to the outputs
  logic [1:0]  gap_q, gap_d;                         // spacing between output edges
  logic [1:0]  og_q, og_d;                           // output gray state {a,b}
  logic        oa_d, ob_d;
  logic        oa_q, ob_q;
  logic signed [1:0] dstep;                          // divided step, -1, 0 or +1

  always_comb begin
    tick_d     = (tick_cnt_q == 13'(UPDATE_CYCLES - 1));
    tick_cnt_d = tick_d ? 13'h0000 : tick_cnt_q + 13'h0001;
    // reversals walk the prescaler back, so direction stays exact
    pre_d = pre_q;
    dstep = 2'sd0;
    if (mv_one) begin
      pre_d = mv_up ? pre_q + 9'sd1 : pre_q - 9'sd1;
    end
    if (pre_d >= $signed({1'b0, div_q}) && div_q != 8'h00) begin
      pre_d = 9'sd0;
      dstep = 2'sd1;                                 // [R16]
    end else if (pre_d <= -$signed({1'b0, div_q}) && div_q != 8'h00) begin
      pre_d = 9'sd0;
      dstep = -2'sd1;                                // [R16]
    end
    // rate for the next interval is fixed only at the boundary
    pend_d  = (tick_q ? 16'sd0 : pend_q) + 16'(dstep);
    burst_d = tick_q ? burst_q + pend_q : burst_q;   // [R15]
    gap_d   = (gap_q != 2'd0) ? gap_q - 2'd1 : gap_q;
    og_d    = og_q;
    if (gap_q == 2'd0 && burst_q != 16'sd0) begin
      gap_d   = 2'(mfil_pkg::STEP_GAP - 1);          // [R14]
      // forward step walks {a,b} 00,10,11,01, the square-wave phasing of the inputs
      og_d    = (burst_q > 16'sd0) ? {~og_q[0], og_q[1]} : {og_q[0], ~og_q[1]};  // [R12]
      burst_d = (burst_q > 16'sd0) ? burst_d - 16'sd1 : burst_d + 16'sd1;
    end
    if (ctrl_q.out_mode == mfil_pkg::MFIL_DIVIDED) begin
      {oa_d, ob_d} = og_q;
    end else begin
      {oa_d, ob_d} = {pin.a, pin.b};                 // filtered pass-through
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= 13'h0000;
      tick_q     <= 1'b0;
      pre_q      <= 9'sd0;
      pend_q     <= 16'sd0;
      burst_q    <= 16'sd0;
      gap_q      <= 2'd0;
      og_q       <= 2'b00;
      oa_q       <= 1'b0;
      ob_q       <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      pre_q      <= pre_d;
      pend_q     <= pend_d;
      burst_q    <= burst_d;
      gap_q      <= gap_d;
      og_q       <= og_d;
      oa_q       <= oa_d;
      ob_q       <= ob_d;
    end
  end

  // ****************************************
  // apb slave and interrupt
  // ****************************************
  assign ev    = {ctrl_q.hall_en && sector == 3'd7, heat_d, pin.idx && !pi_q, mv_both};
  assign wr_en = psel && penable && pready && pwrite && mapped(paddr);

  // one wait state: pready rises in the second access cycle
  always_comb begin
    ctrl_d     = ctrl_q;
    hall_ofs_d = hall_ofs_q;
    div_d      = div_q;
    mask_d     = mask_q;
    stat_d     = stat_q;
    if (wr_en) begin
      case (paddr)
        mfil_pkg::OFS_CTRL:     ctrl_d     = mfil_pkg::mfil_ctrl_t'(pwdata[4:0]);
        mfil_pkg::OFS_HALL_OFS: hall_ofs_d = pwdata[8:0];
        mfil_pkg::OFS_OUT_DIV:  div_d      = pwdata[7:0];
        mfil_pkg::OFS_IRQ_STAT: stat_d     = stat_q & ~pwdata[3:0];
        mfil_pkg::OFS_IRQ_MASK: mask_d     = pwdata[3:0];
        default:                ;                    // read-only offsets
      endcase
    end
    stat_d    = stat_d | ev;                         // set beats clear [R18]
    pready_d  = psel && penable && !pready;
    pslverr_d = pready_d && !mapped(paddr);
    prdata_d  = 32'h0000_0000;
    if (pready_d && !pwrite) begin
      case (paddr)
        mfil_pkg::OFS_CTRL:     prdata_d = {27'h000_0000, ctrl_q};
        mfil_pkg::OFS_HALL_OFS: prdata_d = {23'h00_0000, hall_ofs_q};
        mfil_pkg::OFS_OUT_DIV:  prdata_d = {24'h00_0000, div_q};
        mfil_pkg::OFS_POS:      prdata_d = pos_q;
        mfil_pkg::OFS_IDX_POS:  prdata_d = idx_pos_q;
        mfil_pkg::OFS_STATE:    prdata_d = {9'h000, rev_q, fwd_q, heat_q, ang_ok_q,
                                            pin.hall, 7'h00, ang_q};
        mfil_pkg::OFS_IRQ_STAT: prdata_d = {28'h000_0000, stat_q};
        mfil_pkg::OFS_IRQ_MASK: prdata_d = {28'h000_0000, mask_q};
        default:                prdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q     <= mfil_pkg::mfil_ctrl_t'(mfil_pkg::CTRL_RST);
      hall_ofs_q <= mfil_pkg::HALL_OFS_RST;
      div_q      <= mfil_pkg::OUT_DIV_RST;
      mask_q     <= mfil_pkg::IRQ_MASK_RST;
      stat_q     <= 4'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      irq        <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      hall_ofs_q <= hall_ofs_d;
      div_q      <= div_d;
      mask_q     <= mask_d;
      stat_q     <= stat_d;
      pready     <= pready_d;
      pslverr    <= pslverr_d;
      prdata     <= prdata_d;
      irq        <= irq_d;
    end
  end

  assign enc_out_a        = oa_q;
  assign enc_out_b        = ob_q;
  assign comm_angle       = ang_q;
  assign comm_angle_valid = ang_ok_q;
  assign overheat_fault   = heat_q;
  assign fwd_inhibit      = fwd_q;
  assign rev_inhibit      = rev_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence seq_both_move;
    mv_both;
  endsequence
  sequence seq_up_move;
    mv_one && mv_up;
  endsequence

  chk_filter_settle: assert property ( // [R1]
    $stable(motor_channel_a)[*4] |-> pin.a == motor_channel_a)
    else $error("filtered channel a did not follow a steady input");
  chk_illegal_hold: assert property (seq_both_move |=> $stable(pos_q) && stat_q[0]) // [R2] [R18]
    else $error("illegal change moved count or missed flag");
  chk_count_up: assert property ( // [R3] [R12]
    seq_up_move |=> pos_q == $past(pos_q) + 32'h0000_0001)
    else $error("legal forward edge did not add one");
  chk_hall_off: assert property (!ctrl_q.hall_en |=> !comm_angle_valid) // [R6]
    else $error("angle valid while halls ignored");
  chk_heat_fault: assert property (ctrl_q.thermo_en && pin.thermo |=> overheat_fault) // [R8]
    else $error("open thermostat gave no fault");
  chk_heat_off: assert property (!ctrl_q.thermo_en |=> !overheat_fault) // [R9]
    else $error("fault raised with thermostat ignored");
  chk_limit_side: assert property (motor_limits_en && pin.lim_pos && !pin.lim_neg
                                   |=> fwd_inhibit && !rev_inhibit) // [R10] [R19]
    else $error("positive limit blocked the wrong direction");
  chk_limit_off: assert property (!motor_limits_en |=> !fwd_inhibit && !rev_inhibit) // [R11]
    else $error("limits acted while not configured");
  chk_update_gap: assert property (tick_q |=> (!tick_q)[*8]) // [R15]
    else $error("update boundaries too close");
  chk_out_rate: assert property (ctrl_q.out_mode == mfil_pkg::MFIL_DIVIDED && $changed(og_q)
                                 |=> $stable(og_q)) // [R14]
    else $error("regenerated edges closer than the rate limit");

endmodule : mfil_top

// *** dv/mfil_motor_model.sv ***
// motor side model: quadrature encoder stepped on request from the bench
`timescale 1ns/1ps
module mfil_motor_model (
  input  wire logic core_clk,
  input  wire logic step_fwd,
  input  wire logic step_rev,
  input  wire logic step_bad,
  output logic      motor_channel_a,
  output logic      motor_channel_b
);
  // ****************************************
  // encoder phase
  // ****************************************
  logic [1:0] ph_q = 2'h0;  // quadrature phase, 0..3

  // one phase per forward or reverse request, two for an illegal one; bench spaces requests 5 cycles apart,
  // so the phase error stays far inside the allowed window
  always @(posedge core_clk) begin
    if (step_fwd) begin
      ph_q <= ph_q + 2'h1;
    end else if (step_rev) begin
      ph_q <= ph_q - 2'h1;
    end else if (step_bad) begin
      ph_q <= ph_q + 2'h2;  // both lines flip together
    end
  end

  // {a,b} runs 00,10,11,01 forward, so a leads b
  assign motor_channel_a = ph_q[1] ^ ph_q[0];
  assign motor_channel_b = ph_q[1];
endmodule : mfil_motor_model

// *** dv/mfil_top_bench.sv ***
// bench: motor feedback front end driven over apb and from a motor model
`timescale 1ns/1ps
module mfil_top_bench;
  // ****************************************
  // signals
  // ****************************************
  logic        core_clk = 1'b0, rst_n = 1'b0;       // clock, held reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // apb control
  logic [7:0]  paddr = 8'h00;                       // apb address
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, pos;  // data, last read, expected count
  logic        pready, pslverr, err, motor_channel_a, motor_channel_b, enc_out_a, enc_out_b;
  logic        motor_index = 1'b0, thermostat_in = 1'b0, motor_limits_en = 1'b0;
  logic        hall_sensor_1 = 1'b1, hall_sensor_2 = 1'b0, hall_sensor_3 = 1'b0;
  logic        limit_pos_in = 1'b0, limit_neg_in = 1'b0;  // limits closed
  logic        step_fwd = 1'b0, step_rev = 1'b0, step_bad = 1'b0;  // model requests
  logic [8:0]  comm_angle;                          // commutation angle
  logic        comm_angle_valid, overheat_fault, fwd_inhibit, rev_inhibit, irq;
  logic        ea_q, eb_q;                          // last regenerated levels
  logic [1:0]  e0;                                  // regenerated phase before a step
  logic [2:0]  hc [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};  // sector codes
  int          fails = 0, checks_done = 0, cyc = 0, edges = 0, gap = 0, min_gap = 99;
  int          n, ofs, sgn = 1;                     // sgn flips with sine/cosine phasing

  // short update interval keeps the run brief
  mfil_top #(.UPDATE_CYCLES(20)) u_mfil_top (.*);
  mfil_motor_model u_mfil_motor_model (.*);
  always #25 core_clk = ~core_clk;  // 50 ns period

  // ****************************************
  // output edge watch and timeout
  // ****************************************
  always @(posedge core_clk) begin
    gap = gap + 1;
    if (enc_out_a !== ea_q || enc_out_b !== eb_q) begin
      edges = edges + 1;
      if (gap < min_gap) min_gap = gap;
      gap = 0;
    end
    ea_q = enc_out_a;
    eb_q = enc_out_b;
    cyc = cyc + 1;
    if (cyc == 20000) begin  // far beyond the several hundred cycles needed
      fails = fails + 1;
      complete_run();
    end
  end

  // ****************************************
  // tasks and expectations
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      fails = fails + 1;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  // one apb transfer, then an idle cycle so strobes never toggle twice;
  // the wait has no limit of its own, the cycle timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // 0 forward, 1 reverse, 2 illegal double flip
  task automatic step(input int k);
    step_fwd <= (k == 0);
    step_rev <= (k == 1);
    step_bad <= (k == 2);
    @(posedge core_clk);
    {step_fwd, step_rev, step_bad} <= 3'h0;
    repeat (4) @(posedge core_clk);
    pos = pos + ((k == 0) ? sgn : (k == 1) ? -sgn : 0);
  endtask : step

  function automatic logic [8:0] angle(input int s, input int o);
    return 9'((s * 60 + o) % 360);
  endfunction : angle

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h5e0b_6944));
    pos = 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, mfil_pkg::OFS_CTRL, 32'h0);
    check(rd, {27'h0, mfil_pkg::CTRL_RST});
    apb(1'b1, mfil_pkg::OFS_POS, 32'h1234_5678);  // read-only, ignored
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h20, 32'h0);
    check(err, 1'b1);
    $display("test registers done");
    n = $urandom_range(24, 4);
    for (int i = 0; i < n; i++) step(0);
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    for (int i = 0; i < n + 3; i++) step(1);
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h7);
    sgn = -1;
    step(0);
    step(0);
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    sgn = 1;
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h3);
    $display("test counting done");
    apb(1'b1, mfil_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, mfil_pkg::OFS_IRQ_STAT, 32'hF);
    step(2);
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    apb(1'b0, mfil_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd[0], 1'b1);
    check(irq, 1'b1);
    apb(1'b1, mfil_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 1'b0);
    step(0);
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    $display("test illegal change done");
    motor_index <= 1'b1;
    repeat (6) @(posedge core_clk);
    motor_index <= 1'b0;
    apb(1'b0, mfil_pkg::OFS_IDX_POS, 32'h0);
    check(rd, pos);
    apb(1'b0, mfil_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd[1], 1'b1);
    for (int s = 0; s < 6; s++) begin
      ofs = $urandom_range(359, 0);
      apb(1'b1, mfil_pkg::OFS_HALL_OFS, ofs);
      {hall_sensor_3, hall_sensor_2, hall_sensor_1} <= hc[s];
      repeat (10) @(posedge core_clk);
      check(comm_angle, angle(s, ofs));
      check(comm_angle_valid, 1'b1);
    end
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h2);
    repeat (8) @(posedge core_clk);
    check(comm_angle_valid, 1'b0);
    thermostat_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(overheat_fault, 1'b1);
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h1);
    repeat (8) @(posedge core_clk);
    check(overheat_fault, 1'b0);
    thermostat_in <= 1'b0;
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h3);
    $display("test halls and thermostat done");
    for (int v = 0; v < 8; v++) begin
      {motor_limits_en, limit_neg_in, limit_pos_in} <= v[2:0];
      repeat (8) @(posedge core_clk);
      check(fwd_inhibit, v[2] & v[0]);
      check(rev_inhibit, v[2] & v[1]);
    end
    $display("test limits done");
    step(0);
    @(posedge core_clk);
    check({enc_out_a, enc_out_b}, {motor_channel_a, motor_channel_b});
    apb(1'b1, mfil_pkg::OFS_OUT_DIV, 32'h2);
    apb(1'b1, mfil_pkg::OFS_CTRL, 32'h13);
    repeat (60) @(posedge core_clk);
    edges = 0;
    min_gap = 99;
    for (int i = 0; i < 8; i++) step(0);
    repeat (80) @(posedge core_clk);
    check(edges, 4);
    check(min_gap >= mfil_pkg::STEP_GAP, 1'b1);
    e0 = {enc_out_a, enc_out_b};
    step(0);
    step(0);
    repeat (40) @(posedge core_clk);
    check({enc_out_a, enc_out_b}, {~e0[0], e0[1]});
    apb(1'b0, mfil_pkg::OFS_POS, 32'h0);
    check(rd, pos);
    $display("test regeneration done");
    complete_run();
  end
endmodule : mfil_top_bench
